// ---- rtl/encemu_defs.svh ----
// Offsets, field positions, reset values and timing counts of the encoder emulation
`ifndef ENCEMU_DEFS_SVH
`define ENCEMU_DEFS_SVH
`define REG_CTRL 8'h00
`define REG_LINES 8'h04
`define REG_OFFSET 8'h08
`define REG_NVSAVE 8'h0c
`define REG_STATUS 8'h10
`define REG_EMU 8'h14
`define CTRL_MODE_LSB 0
`define CTRL_FBENC_BIT 2
`define CTRL_GRAY_BIT 3
`define CTRL_TOUT_BIT 4
`define CTRL_REV_BIT 5
`define CTRL_INTERP_LSB 6
`define CTRL_GEAR_LSB 8
`define CTRL_REVBITS_LSB 16
`define MODE_RST 2'h1
`define LINES_RST 20'h00400
`define REVBITS_RST 5'h0c
`define RES_LINES_MIN 20'h00020
`define RES_LINES_MAX 20'h01000
`define ENC_LINES_MIN 20'h00100
`define ENC_LINES_MAX 20'h80000
`define REVBITS_MIN 5'h0c
`define REVBITS_MAX 5'h10
`define ANGLE_BITS 16
`define CLK_PERIOD_NS 40
`define EDGE_SPACING_NS 200
`define EDGE_CYCLES ((`EDGE_SPACING_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TOUT_SHORT_NS 3000
`define TOUT_LONG_NS 13000
`define TOUT_SHORT_CYCLES ((`TOUT_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TOUT_LONG_CYCLES ((`TOUT_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- rtl/encemu_pkg.sv ----
// Types shared by the encoder emulation files
package encemu_pkg;
  typedef enum logic [1:0] {
    ENC_OFF = 2'h0,
    ENC_INCR = 2'h1,
    ENC_SERIAL = 2'h2,
    ENC_INTERP = 2'h3
  } enc_mode_t;
  typedef enum logic [1:0] {
    SER_IDLE = 2'h0,
    SER_SHIFT = 2'h1,
    SER_TAIL = 2'h3
  } ser_state_t;
  typedef struct packed {
    logic [15:0] angle;
  } pos_sample_t;
  typedef struct packed {
    logic chan_a;
    logic chan_b;
    logic zero_index_pulse;
  } quad_out_t;
  typedef struct packed {
    enc_mode_t encoder_function_select;
    logic feedback_type_select;
    logic gray_select;
    logic serial_timeout_select;
    logic count_reverse;
    logic [1:0] interp_exp;
    logic [4:0] gearing_source_select;
    logic [4:0] serial_revolution_bits;
    logic [19:0] output_line_count;
    logic [15:0] zero_pulse_offset;
  } enc_cfg_t;
endpackage

// ---- rtl/pos_skid_buffer.sv ----
// Two-entry buffer for position samples
`timescale 1ns/1ps
module pos_skid_buffer #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic wr;
    logic rd;
    logic [1:0] cnt;
    logic rdy;
  } buf_st_t;

  buf_st_t s_ff;
  buf_st_t nxt_s;
  logic push;
  logic pop;

  always_comb begin
    nxt_s = s_ff;
    push = in_valid_i & s_ff.rdy;
    pop = out_ready_i & (s_ff.cnt != 2'h0);
    if (push) begin
      nxt_s.mem[s_ff.wr] = in_data_i;
      nxt_s.wr = ~s_ff.wr;
    end
    if (pop) begin
      nxt_s.rd = ~s_ff.rd;
    end
    nxt_s.cnt = s_ff.cnt + {1'b0, push} - {1'b0, pop};
    nxt_s.rdy = (nxt_s.cnt != 2'h2);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_ff <= '0;
      s_ff.rdy <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign in_ready_o = s_ff.rdy;
  assign out_valid_o = (s_ff.cnt != 2'h0);
  assign out_data_o = s_ff.mem[s_ff.rd];
endmodule

// ---- rtl/encoder_emulation_output.sv ----
// Encoder emulation: quadrature, interpolated and serial absolute position outputs
`timescale 1ns/1ps
`include "encemu_defs.svh"
module encoder_emulation_output (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic fb_valid_i,
  input wire encemu_pkg::pos_sample_t fb_sample_i,
  output logic fb_ready_o,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_zero_i,
  input wire logic ssi_clk_i,
  output logic ssi_data_o,
  output encemu_pkg::quad_out_t incremental_pulse_output_o,
  input wire logic [15:0] nv_offset_i,
  output logic nv_save_o,
  output logic [15:0] nv_data_o
);
  import encemu_pkg::*;

  localparam logic [2:0] EDGE_CYC = 3'(`EDGE_CYCLES);
  localparam logic [8:0] TOUT_SHORT = 9'(`TOUT_SHORT_CYCLES);
  localparam logic [8:0] TOUT_LONG = 9'(`TOUT_LONG_CYCLES);

  typedef struct packed {
    enc_cfg_t cfg;
    logic [31:0] rdata;
    logic ready;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic nv_loaded;
    logic nv_save;
    logic [15:0] nv_data;
    logic [15:0] angle;
    logic [15:0] revs;
    logic [22:0] interp_tgt;
    logic [22:0] emu;
    logic [2:0] space;
    quad_out_t quad;
    logic [2:0] a_s;
    logic [2:0] b_s;
    logic [2:0] z_s;
    logic [2:0] c_s;
    ser_state_t sst;
    logic [31:0] shreg;
    logic [5:0] bits_left;
    logic [8:0] tout;
    logic sdata;
  } st_t;

  st_t s_ff;
  st_t nxt_s;

  logic buf_valid;
  pos_sample_t buf_data;
  logic buf_ready;
  logic [31:0] rd_word;
  logic rd_take;
  logic [19:0] lines_eff;
  logic [23:0] wrapv;
  logic [15:0] ang_adj;
  logic [37:0] prod;
  logic [22:0] tgt;
  logic [23:0] diff;
  logic [1:0] q_new;
  logic [1:0] q_old;
  logic [1:0] dq;
  logic [22:0] istep;
  logic c_rise;
  logic c_fall;
  logic [4:0] rbits;
  logic [31:0] pos32;
  logic [31:0] field;
  logic [31:0] frame;
  logic [8:0] tout_lim;
  logic pulse_mode;
  logic emu_wrap;
  logic [5:0] frame_len;

  pos_skid_buffer #(
    .WIDTH($bits(pos_sample_t))
  ) u_fb_buf (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(fb_valid_i),
    .in_data_i(fb_sample_i),
    .in_ready_o(fb_ready_o),
    .out_valid_o(buf_valid),
    .out_data_o(buf_data),
    .out_ready_i(buf_ready)
  );

  always_comb begin
    nxt_s = s_ff;
    nxt_s.nv_save = 1'b0;
    // Pin synchronisers, [1] synced, [2] previous
    nxt_s.a_s = {s_ff.a_s[1:0], enc_a_i};
    nxt_s.b_s = {s_ff.b_s[1:0], enc_b_i};
    nxt_s.z_s = {s_ff.z_s[1:0], enc_zero_i};
    nxt_s.c_s = {s_ff.c_s[1:0], ssi_clk_i};

    // Offset restored once after reset
    if (!s_ff.nv_loaded) begin
      nxt_s.cfg.zero_pulse_offset = nv_offset_i;
      nxt_s.nv_loaded = 1'b1;
    end

    // Bus write data phase
    if (s_ff.wr_pend) begin
      case (s_ff.wr_addr)
        `REG_CTRL: begin
          nxt_s.cfg.encoder_function_select = enc_mode_t'(hwdata_i[`CTRL_MODE_LSB +: 2]);
          nxt_s.cfg.feedback_type_select = hwdata_i[`CTRL_FBENC_BIT];
          nxt_s.cfg.gray_select = hwdata_i[`CTRL_GRAY_BIT];
          nxt_s.cfg.serial_timeout_select = hwdata_i[`CTRL_TOUT_BIT];
          nxt_s.cfg.count_reverse = hwdata_i[`CTRL_REV_BIT];
          nxt_s.cfg.interp_exp = hwdata_i[`CTRL_INTERP_LSB +: 2];
          nxt_s.cfg.gearing_source_select = hwdata_i[`CTRL_GEAR_LSB +: 5];
          nxt_s.cfg.serial_revolution_bits = hwdata_i[`CTRL_REVBITS_LSB +: 5];
        end
        `REG_LINES: begin
          nxt_s.cfg.output_line_count = hwdata_i[19:0];
        end
        `REG_OFFSET: begin
          nxt_s.cfg.zero_pulse_offset = hwdata_i[15:0];
        end
        `REG_NVSAVE: begin
          nxt_s.nv_save = 1'b1;
          nxt_s.nv_data = s_ff.cfg.zero_pulse_offset;
        end
        default: begin
        end
      endcase
    end

    // Bus address phase
    rd_take = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
    nxt_s.wr_pend = hsel_i & hready_i & htrans_i[1] & hwrite_i & (hsize_i == 3'h2) &
                    (haddr_i[31:8] == 24'h00_0000);
    nxt_s.wr_addr = haddr_i[7:0];
    rd_word = 32'h0000_0000;
    case (haddr_i[7:0])
      `REG_CTRL: rd_word = {11'h000, s_ff.cfg.serial_revolution_bits, 3'h0, s_ff.cfg.gearing_source_select,
                            s_ff.cfg.interp_exp, s_ff.cfg.count_reverse, s_ff.cfg.serial_timeout_select,
                            s_ff.cfg.gray_select, s_ff.cfg.feedback_type_select,
                            s_ff.cfg.encoder_function_select};
      `REG_LINES: rd_word = {12'h000, s_ff.cfg.output_line_count};
      `REG_OFFSET: rd_word = {16'h0000, s_ff.cfg.zero_pulse_offset};
      `REG_STATUS: rd_word = {s_ff.revs, s_ff.angle};
      `REG_EMU: rd_word = {(s_ff.sst != SER_IDLE), 8'h00, s_ff.emu};
      default: rd_word = 32'h0000_0000;
    endcase
    nxt_s.rdata = (rd_take && haddr_i[31:8] == 24'h00_0000) ? rd_word : 32'h0000_0000;

    // Line count limits by feedback type
    // Register keeps the written value, limits apply here
    lines_eff = s_ff.cfg.output_line_count;
    if (s_ff.cfg.feedback_type_select) begin
      if (lines_eff < `ENC_LINES_MIN) lines_eff = `ENC_LINES_MIN;
      if (lines_eff > `ENC_LINES_MAX) lines_eff = `ENC_LINES_MAX;
    end else begin
      if (lines_eff < `RES_LINES_MIN) lines_eff = `RES_LINES_MIN;
      if (lines_eff > `RES_LINES_MAX) lines_eff = `RES_LINES_MAX;
    end
    pulse_mode = (s_ff.cfg.encoder_function_select == ENC_INCR) ||
                 (s_ff.cfg.encoder_function_select == ENC_INTERP);
    wrapv = (s_ff.cfg.encoder_function_select == ENC_INTERP) ? 24'h80_0000 : {2'b00, lines_eff, 2'b00};

    // Angle scaled to quadrature states within one revolution
    ang_adj = (s_ff.cfg.count_reverse ? 16'(16'h0000 - s_ff.angle) : s_ff.angle) -
              s_ff.cfg.zero_pulse_offset;
    prod = {22'h00_0000, ang_adj} * {16'h0000, lines_eff, 2'b00};
    tgt = (s_ff.cfg.encoder_function_select == ENC_INTERP) ? s_ff.interp_tgt : {1'b0, prod[37:16]};
    if ({1'b0, tgt} >= {1'b0, s_ff.emu}) begin
      diff = {1'b0, tgt} - {1'b0, s_ff.emu};
    end else begin
      diff = {1'b0, tgt} + wrapv - {1'b0, s_ff.emu};
    end

    // Quadrature stepping, one edge per spacing interval
    emu_wrap = ({1'b0, s_ff.emu} >= wrapv);
    if (emu_wrap) begin
      // Shrunk range keeps the AB phase, so no double edge
      nxt_s.emu = {21'h00_0000, s_ff.emu[1:0]};
    end else if (s_ff.space != 3'h0) begin
      nxt_s.space = s_ff.space - 3'h1;
    end else if (pulse_mode && diff != 24'h00_0000) begin
      if (diff <= (wrapv >> 1)) begin
        nxt_s.emu = ({1'b0, s_ff.emu} == wrapv - 24'h1) ? 23'h00_0000 : s_ff.emu + 23'h1;
      end else begin
        nxt_s.emu = (s_ff.emu == 23'h00_0000) ? 23'(wrapv - 24'h1) : s_ff.emu - 23'h1;
      end
      nxt_s.space = EDGE_CYC - 3'h1;
    end
    nxt_s.quad.chan_a = pulse_mode & (nxt_s.emu[1] ^ nxt_s.emu[0]);
    nxt_s.quad.chan_b = pulse_mode & nxt_s.emu[1];
    if (s_ff.cfg.encoder_function_select == ENC_INCR) begin
      nxt_s.quad.zero_index_pulse = (nxt_s.emu == 23'h00_0002);
    end else if (s_ff.cfg.encoder_function_select == ENC_INTERP) begin
      nxt_s.quad.zero_index_pulse = s_ff.z_s[1];
    end else begin
      nxt_s.quad.zero_index_pulse = 1'b0;
    end

    // Feedback samples, stalled in incremental mode while pulses lag behind
    buf_ready = (s_ff.cfg.encoder_function_select != ENC_INCR) || (diff == 24'h00_0000);
    if (buf_valid && buf_ready) begin
      nxt_s.angle = buf_data.angle;
      if (s_ff.angle[15:14] == 2'b11 && buf_data.angle[15:14] == 2'b00) begin
        nxt_s.revs = s_ff.revs + 16'h0001;
      end else if (s_ff.angle[15:14] == 2'b00 && buf_data.angle[15:14] == 2'b11) begin
        nxt_s.revs = s_ff.revs - 16'h0001;
      end
    end

    // Interpolation of the input encoder
    q_new = {s_ff.b_s[1], s_ff.a_s[1] ^ s_ff.b_s[1]};
    q_old = {s_ff.b_s[2], s_ff.a_s[2] ^ s_ff.b_s[2]};
    dq = q_new - q_old;
    istep = 23'h00_0010 << s_ff.cfg.interp_exp;
    if (s_ff.cfg.encoder_function_select == ENC_INTERP) begin
      if (dq == 2'h1) begin
        nxt_s.interp_tgt = s_ff.cfg.count_reverse ? s_ff.interp_tgt - istep : s_ff.interp_tgt + istep;
      end else if (dq == 2'h3) begin
        nxt_s.interp_tgt = s_ff.cfg.count_reverse ? s_ff.interp_tgt + istep : s_ff.interp_tgt - istep;
      end
    end

    // Serial frame build
    c_rise = s_ff.c_s[1] & ~s_ff.c_s[2];
    c_fall = ~s_ff.c_s[1] & s_ff.c_s[2];
    rbits = s_ff.cfg.serial_revolution_bits;
    if (rbits < `REVBITS_MIN) rbits = `REVBITS_MIN;
    if (rbits > `REVBITS_MAX) rbits = `REVBITS_MAX;
    pos32 = {s_ff.revs, s_ff.angle};
    if (s_ff.cfg.count_reverse) begin
      pos32 = 32'h0000_0000 - pos32;
    end
    // Frame length in bits, up to 32
    frame_len = {1'b0, rbits} + 6'h10;
    field = pos32 & ~(32'hffff_ffff << frame_len);
    if (s_ff.cfg.gray_select) begin
      field = field ^ (field >> 1);
    end
    frame = field << (5'h10 - rbits);
    tout_lim = s_ff.cfg.serial_timeout_select ? TOUT_LONG : TOUT_SHORT;

    // Serial shift state machine
    unique case (s_ff.sst)
      SER_IDLE: begin
        nxt_s.sdata = 1'b1;
        nxt_s.tout = 9'h000;
        if (s_ff.cfg.encoder_function_select == ENC_SERIAL && c_fall) begin
          nxt_s.shreg = frame;
          nxt_s.bits_left = frame_len;
          nxt_s.sst = SER_SHIFT;
        end
      end
      SER_SHIFT: begin
        if (c_rise) begin
          nxt_s.sdata = s_ff.shreg[31];
          nxt_s.shreg = {s_ff.shreg[30:0], 1'b0};
          nxt_s.bits_left = s_ff.bits_left - 6'h01;
          if (s_ff.bits_left == 6'h01) begin
            nxt_s.sst = SER_TAIL;
          end
        end
      end
      SER_TAIL: begin
        if (c_rise) begin
          nxt_s.sdata = 1'b0;
        end
      end
      default: begin
        nxt_s.sst = SER_IDLE;
      end
    endcase
    if (s_ff.sst != SER_IDLE) begin
      nxt_s.tout = (c_rise | c_fall) ? 9'h000 : s_ff.tout + 9'h001;
      if (s_ff.tout >= tout_lim - 9'h001 ||
          s_ff.cfg.encoder_function_select != ENC_SERIAL) begin
        nxt_s.sst = SER_IDLE;
        nxt_s.sdata = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_ff <= '0;
      s_ff.cfg.encoder_function_select <= enc_mode_t'(`MODE_RST);
      s_ff.cfg.output_line_count <= `LINES_RST;
      s_ff.cfg.serial_revolution_bits <= `REVBITS_RST;
      s_ff.ready <= 1'b1;
      s_ff.sst <= SER_IDLE;
      s_ff.sdata <= 1'b1;
      // Serial clock pin idles high
      s_ff.c_s <= 3'h7;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign hrdata_o = s_ff.rdata;
  assign hreadyout_o = s_ff.ready;
  assign hresp_o = 1'b0;
  assign ssi_data_o = s_ff.sdata;
  assign incremental_pulse_output_o = s_ff.quad;
  assign nv_save_o = s_ff.nv_save;
  assign nv_data_o = s_ff.nv_data;
endmodule

// ---- bench/encoder_emulation_output_chk.sv ----
// Port checker for the encoder emulation block
`timescale 1ns/1ps
module encoder_emulation_output_chk
  import encemu_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic ssi_clk_i,
  input wire logic ssi_data_o,
  input wire encemu_pkg::quad_out_t incremental_pulse_output_o,
  input wire logic nv_save_o
);
  logic wr_ctrl_ff;
  logic [1:0] mode_ff;
  logic clk_seen_ff;
  logic [8:0] idle_ff;
  logic [1:0] ab;
  assign ab = {incremental_pulse_output_o.chan_a, incremental_pulse_output_o.chan_b};
  // Mode tracking and serial clock idle time
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ctrl_ff <= 1'b0;
      mode_ff <= 2'h1;
      clk_seen_ff <= 1'b1;
      idle_ff <= 9'h0;
    end else begin
      wr_ctrl_ff <= hsel_i && hready_i && htrans_i[1] && hwrite_i && hsize_i == 3'h2 && haddr_i == 32'h0;
      if (wr_ctrl_ff) mode_ff <= hwdata_i[1:0];
      clk_seen_ff <= ssi_clk_i;
      idle_ff <= (ssi_clk_i != clk_seen_ff) ? 9'h0 : (idle_ff == 9'h1ff ? idle_ff : idle_ff + 9'h1);
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence in_incr;
    (mode_ff == 2'h1)[*3];
  endsequence
  sequence save_req;
    hsel_i && hready_i && htrans_i[1] && hwrite_i && hsize_i == 3'h2 && haddr_i == 32'hc;
  endsequence
  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
  a_read_quiet: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i) |=> hrdata_o == 32'h0)
    else $error("read data without a read");
  a_zero_at_ab: assert property (in_incr |-> !incremental_pulse_output_o.zero_index_pulse || ab == 2'h3)
    else $error("zero pulse outside A=B=1");
  a_single_step: assert property (in_incr |-> !($changed(ab[1]) && $changed(ab[0])))
    else $error("both channels changed together");
  a_edge_spacing: assert property (in_incr ##0 $changed(ab) |=> $stable(ab)[*4])
    else $error("channel edges closer than five cycles");
  a_serial_quiet: assert property ((mode_ff == 2'h2)[*3] |-> incremental_pulse_output_o == 3'h0)
    else $error("pulses in serial mode");
  a_save_follows: assert property (save_req |-> ##[1:4] nv_save_o)
    else $error("offset save not requested");
  a_save_pulse: assert property (nv_save_o |=> !nv_save_o)
    else $error("save request longer than one cycle");
  a_idle_high: assert property (idle_ff >= 9'h154 |-> ssi_data_o)
    else $error("serial data not idle after timeout");
endmodule
bind encoder_emulation_output encoder_emulation_output_chk chk (.*);

// ---- bench/ssi_reader_model.sv ----
// Serial position reader on the far side of the serial output
`timescale 1ns/1ps
module ssi_reader_model (
  output logic ssi_clk_o,
  input wire logic ssi_data_i
);
  initial ssi_clk_o = 1'b1;
  // One frame: falling edge latches, each rise shifts, sample on the fall
  task automatic read_frame(input int nbits, output logic [31:0] val);
    val = 32'h0;
    #10;
    ssi_clk_o = 1'b0;
    #320;
    for (int i = 0; i < nbits; i++) begin
      ssi_clk_o = 1'b1;
      #320;
      ssi_clk_o = 1'b0;
      val = {val[30:0], ssi_data_i};
      #320;
    end
    ssi_clk_o = 1'b1;
    #14000;
  endtask
endmodule

// ---- bench/encoder_emulation_output_tb.sv ----
// Self-checking bench for the encoder emulation block
`timescale 1ns/1ps
module encoder_emulation_output_tb;
  import encemu_pkg::*;
  logic clk_i, reset_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, fb_valid_i, fb_ready_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic enc_a_i, enc_b_i, enc_zero_i, ssi_clk_i, ssi_data_o, nv_save_o;
  logic [15:0] nv_offset_i, nv_data_o;
  pos_sample_t fb_sample_i;
  quad_out_t incremental_pulse_output_o;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  encoder_emulation_output DUT (.hready_i(hreadyout_o), .*);
  ssi_reader_model rdr (.ssi_clk_o(ssi_clk_i), .ssi_data_i(ssi_data_o));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  // Single AHB transfer with an idle cycle before it
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= wr;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(what, exp, x);
  endtask
  task automatic put_angle(input logic [15:0] a);
    @(posedge clk_i);
    fb_valid_i <= 1'b1;
    fb_sample_i.angle <= a;
    do @(posedge clk_i); while (fb_ready_o !== 1'b1);
    fb_valid_i <= 1'b0;
  endtask
  task automatic frame(input string what, input int n, input logic [31:0] exp);
    logic [31:0] x;
    repeat (20) @(posedge clk_i);
    rdr.read_frame(n, x);
    chk(what, exp, x);
  endtask
  task automatic step(input logic a, input logic b);
    @(posedge clk_i);
    enc_a_i <= a;
    enc_b_i <= b;
    repeat (100) @(posedge clk_i);
  endtask
  initial begin
    reset_i = 1'b1;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    fb_valid_i = 1'b0;
    fb_sample_i = '0;
    enc_a_i = 1'b0;
    enc_b_i = 1'b0;
    enc_zero_i = 1'b0;
    nv_offset_i = 16'h0055;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    rdchk("ctrl reset", 32'h0, 32'h000c0001);
    rdchk("lines reset", 32'h4, 32'h00000400);
    rdchk("offset reload", 32'h8, 32'h00000055);
    rdchk("unmapped", 32'h20, 32'h0);
    $display("test reset done");
    wr(32'h8, 32'h0);
    wr(32'h4, 32'h10);
    rdchk("lines raw", 32'h4, 32'h10);
    put_angle(16'h4200);
    repeat (400) @(posedge clk_i);
    rdchk("status", 32'h10, 32'h00004200);
    rdchk("count up", 32'h14, 32'h21);
    chk("pins", 32'h4, {29'h0, incremental_pulse_output_o});
    put_angle(16'h2000);
    repeat (400) @(posedge clk_i);
    rdchk("count down", 32'h14, 32'h10);
    $display("test incremental done");
    wr(32'h0, 32'h000c0002);
    put_angle(16'h1234);
    frame("frame binary", 28, 32'h1234);
    wr(32'h0, 32'h000c000a);
    frame("frame gray", 28, 32'h1234 ^ (32'h1234 >> 1));
    wr(32'h0, 32'h000c0022);
    frame("frame reverse", 28, 32'h0fffedcc);
    wr(32'h0, 32'h00140012);
    rdchk("revbits raw", 32'h0, 32'h00140012);
    put_angle(16'h7000);
    put_angle(16'hc000);
    put_angle(16'h1000);
    frame("frame 32 bits", 32, 32'h00011000);
    $display("test serial done");
    wr(32'h8, 32'h0123);
    wr(32'hc, 32'h1);
    repeat (4) @(posedge clk_i);
    chk("nv data", 32'h0123, {16'h0, nv_data_o});
    wr(32'h0, 32'h000c0007);
    repeat (100) @(posedge clk_i);
    rdchk("interp start", 32'h14, 32'h0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
    rdchk("interp count", 32'h14, 32'h40);
    enc_zero_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("zero through", 32'h1, {31'h0, incremental_pulse_output_o.zero_index_pulse});
    enc_zero_i <= 1'b0;
    $display("test interpolation done");
    end_of_test();
  end
endmodule
